/* File: verification/sprs_strap_model.sv */
// board strap model: drives the wanted codes through reset, then other pin traffic
`timescale 1ns/1ps
module sprs_strap_model (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// wanted strap codes
	input wire logic [3:0] i_plat_code,
	input wire logic [2:0] i_core_code,
	// strap pins
	output logic [3:0] o_plat_pins,
	output logic [2:0] o_core_pins
);
	logic done_q;
	logic [6:0] noise_q;

	// the pins are shared, so after capture they carry a pattern that moves every cycle on all pins but o_core_pins[0], which stays inverted
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			done_q <= 1'b0;
			noise_q <= 7'h55;
		end else begin
			done_q <= 1'b1;
			noise_q <= ~noise_q + 7'h01;
		end
	end

	// every pin is driven to the wanted level until the capture edge has passed
	assign o_plat_pins = done_q ? (i_plat_code ^ noise_q[6:3]) : i_plat_code;
	assign o_core_pins = done_q ? (i_core_code ^ noise_q[2:0]) : i_core_code;
endmodule // sprs_strap_model

/* File: verification/tb_top.sv */
// testbench for the strap ratio select block
`timescale 1ns/1ps
module tb_top;
	import sprs_pkg::*;
	logic i_clk_sys, i_reset_n;
	logic [3:0] plat_code, plat_pins;
	logic [2:0] core_code, core_pins;
	sprs_plat_ratio_type o_plat_ratio;
	sprs_core_ratio_type o_core_ratio;
	logic [4:0] o_mem_mult_halves;
	logic o_ratios_valid, o_range_ok;
	int n_fail, checks;
	// expected multipliers by code; zero marks a reserved code
	logic [4:0] plat_tab [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
		5'h08, 5'h09, 5'h0a, 5'h00, 5'h0c, 5'h14, 5'h00, 5'h00};
	logic [3:0] core_tab [8] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

	sprs_strap_model board (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_plat_code(plat_code), .i_core_code(core_code),
		.o_plat_pins(plat_pins), .o_core_pins(core_pins));

	sprs_strap_ratio uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_platform_ratio_strap(plat_pins), .i_core_ratio_strap_bit2(core_pins[2]),
		.i_core_ratio_strap_bit1(core_pins[1]), .i_core_ratio_strap_bit0(core_pins[0]),
		.o_plat_ratio(o_plat_ratio), .o_core_ratio(o_core_ratio),
		.o_mem_mult_halves(o_mem_mult_halves), .o_ratios_valid(o_ratios_valid),
		.o_range_ok(o_range_ok));

	// 100 MHz system clock
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// reset for 3 cycles with the given straps, return just after the capture edge
	task automatic power_up(input logic [3:0] p, input logic [2:0] c);
		@(posedge i_clk_sys);
		i_reset_n <= 1'b0;
		plat_code <= p;
		core_code <= c;
		repeat (3) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		@(posedge i_clk_sys);
		#1;
	endtask

	// every platform code, reserved ones included
	task automatic plat_codes();
		for (int i = 0; i < 16; i++) begin
			power_up(4'(i), 3'h4);
			check("plat_ratio", 8'(o_plat_ratio), {2'b00, plat_tab[i], plat_tab[i] == 5'h00});
			check("mem_mult", {3'b000, o_mem_mult_halves}, {3'b000, plat_tab[i]});
		end
	endtask

	// every core code, the reserved one included
	task automatic core_codes();
		for (int i = 0; i < 8; i++) begin
			power_up(4'h4, 3'(i));
			check("core_ratio", 8'(o_core_ratio), {3'b000, core_tab[i], core_tab[i] == 4'h0});
		end
	endtask

	// pin traffic after capture must not move the ratios; a mid-run reset clears them
	task automatic hold_latch();
		power_up(4'h9, 3'h6);
		repeat (20) @(posedge i_clk_sys);
		#1;
		check("valid", {7'h00, o_ratios_valid}, 8'h01);
		check("plat_held", 8'(o_plat_ratio), {2'b00, 5'h09, 1'b0});
		check("core_held", 8'(o_core_ratio), {3'b000, 4'h6, 1'b0});
		@(posedge i_clk_sys);
		i_reset_n <= 1'b0;
		@(posedge i_clk_sys);
		#1;
		check("valid_rst", {7'h00, o_ratios_valid}, 8'h00);
		check("plat_rst", 8'(o_plat_ratio), 8'h00);
	endtask

	// legal and illegal strap pairs at a 100 MHz reference
	task automatic range_cases();
		logic [3:0] p [8] = '{4'h4, 4'h5, 4'h2, 4'h4, 4'h3, 4'h6, 4'h1, 4'h4};
		logic [2:0] c [8] = '{3'h4, 3'h4, 3'h4, 3'h0, 3'h5, 3'h4, 3'h4, 3'h2};
		logic ok [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		for (int i = 0; i < 8; i++) begin
			power_up(p[i], c[i]);
			check("range_early", {7'h00, o_range_ok}, 8'h00);
			@(posedge i_clk_sys);
			#1;
			check("range_ok", {7'h00, o_range_ok}, {7'h00, ok[i]});
		end
	endtask

	// hang guard
	initial begin
		repeat (50000) @(posedge i_clk_sys);
		n_fail++;
		stop_test();
	end

	initial begin
		i_reset_n = 1'b0;
		plat_code = 4'h0;
		core_code = 3'h0;
		n_fail = 0;
		checks = 0;
		plat_codes();
		core_codes();
		hold_latch();
		range_cases();
		stop_test();
	end
endmodule // tb_top

/* File: verilog/sprs_params.svh */
// constants for the strap ratio select block: strap codes, ratios and frequency limits
`ifndef SPRS_PARAMS_SVH
`define SPRS_PARAMS_SVH

// platform ratio strap codes (multiplier of reference clock)
`define SPRS_PLAT_CODE_16 4'h0
`define SPRS_PLAT_CODE_2 4'h2
`define SPRS_PLAT_CODE_3 4'h3
`define SPRS_PLAT_CODE_4 4'h4
`define SPRS_PLAT_CODE_5 4'h5
`define SPRS_PLAT_CODE_6 4'h6
`define SPRS_PLAT_CODE_8 4'h8
`define SPRS_PLAT_CODE_9 4'h9
`define SPRS_PLAT_CODE_10 4'ha
`define SPRS_PLAT_CODE_12 4'hc
`define SPRS_PLAT_CODE_20 4'hd

// core ratio strap codes; ratio held in half steps (core = plat * halves / 2)
`define SPRS_CORE_CODE_4_1 3'h0
`define SPRS_CORE_CODE_9_2 3'h1
`define SPRS_CORE_CODE_RSVD 3'h2
`define SPRS_CORE_CODE_3_2 3'h3
`define SPRS_CORE_CODE_2_1 3'h4
`define SPRS_CORE_CODE_5_2 3'h5
`define SPRS_CORE_CODE_3_1 3'h6
`define SPRS_CORE_CODE_7_2 3'h7

// memory bus clock divisor relative to platform clock
`define SPRS_MEM_DIV 2

// operating limits in MHz, all but SPRS_MEM_MAX_LOW_MHZ used by the range checker
`define SPRS_PLAT_MIN_MHZ 333
`define SPRS_CORE_MIN_MHZ 800
`define SPRS_CORE_MAX_MHZ 1333
`define SPRS_MEM_MIN_MHZ 166
`define SPRS_MEM_MAX_MHZ 266
`define SPRS_MEM_MAX_LOW_MHZ 200
`define SPRS_REF_MAX_SLOW_MHZ 100
`define SPRS_CORE_FAST_MHZ 1200

// reset values of the latched ratios
`define SPRS_PLAT_MULT_RST 5'h00
`define SPRS_CORE_HALF_RST 4'h0

`endif

/* File: verilog/sprs_pkg.sv */
// types for the strap ratio select block
package sprs_pkg;

	// decoded platform ratio
	typedef struct packed {
		logic [4:0] mult;
		logic reserved;
	} sprs_plat_ratio_type;

	// decoded core ratio in half steps
	typedef struct packed {
		logic [3:0] halves;
		logic reserved;
	} sprs_core_ratio_type;

	// raw strap pins
	typedef struct packed {
		logic [3:0] plat;
		logic [2:0] core;
	} sprs_straps_type;

	// latch sequencer states
	typedef enum logic [1:0] {
		SPRS_IN_RESET = 2'b00,
		SPRS_SAMPLE = 2'b01,
		SPRS_LOCKED = 2'b10
	} sprs_state_type;

endpackage : sprs_pkg

/* File: verilog/sprs_range_check.sv */
// frequency range checker for the chosen ratios
`timescale 1ns/1ps
`include "sprs_params.svh"

module sprs_range_check #(
	parameter int REF_MHZ = 100,
	parameter int CORE_MAX_MHZ = `SPRS_CORE_MAX_MHZ,
	parameter int MEM_MAX_MHZ = `SPRS_MEM_MAX_MHZ
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// latched ratios
	input wire sprs_pkg::sprs_plat_ratio_type i_plat,
	input wire sprs_pkg::sprs_core_ratio_type i_core,
	input wire logic i_valid,
	// result
	output logic o_range_ok
);
	import sprs_pkg::*;

	initial begin
		if (REF_MHZ < 1 || CORE_MAX_MHZ < `SPRS_CORE_MIN_MHZ) begin
			$error("sprs_range_check: bad frequency parameters");
		end
	end

	logic [15:0] plat_mhz;
	logic [15:0] core_mhz;
	logic [15:0] mem_mhz;
	logic ok_plat;
	logic ok_core;
	logic ok_mem;
	logic ok_ref;

	// derived frequencies; integer MHz is coarse but enough for a limit check
	assign plat_mhz = 16'(REF_MHZ * int'(i_plat.mult));
	assign core_mhz = 16'((int'(plat_mhz) * int'(i_core.halves)) / 2);
	assign mem_mhz = 16'(int'(plat_mhz) / `SPRS_MEM_DIV);
	assign ok_plat = plat_mhz >= 16'(`SPRS_PLAT_MIN_MHZ); // see (R8)
	assign ok_core = core_mhz >= 16'(`SPRS_CORE_MIN_MHZ) && core_mhz <= 16'(CORE_MAX_MHZ); // see (R9)
	assign ok_mem = mem_mhz >= 16'(`SPRS_MEM_MIN_MHZ) && mem_mhz <= 16'(MEM_MAX_MHZ); // see (R10)
	assign ok_ref = core_mhz >= 16'(`SPRS_CORE_FAST_MHZ) ||
		REF_MHZ <= `SPRS_REF_MAX_SLOW_MHZ; // see (R11)

	// registered verdict; all limits judged together
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_range_ok <= 1'b0;
		end else begin
			o_range_ok <= i_valid && !i_plat.reserved && !i_core.reserved &&
				ok_plat && ok_core && ok_mem && ok_ref; // see (R12)
		end
	end

endmodule // sprs_range_check

/* File: verilog/sprs_strap_ratio.sv */
// strap sampling and decode of platform and core clock ratios
`timescale 1ns/1ps
`include "sprs_params.svh"

// Function
// (R1) platform clock equals reference times strap ratio
// (R2) four-bit platform code decodes to eleven multipliers
// (R3) board must drive every platform strap pin
// (R4) core clock from platform via three-pin ratio
// (R5) three-bit core code decodes; 010 reserved
// (R6) platform frequency chosen equal to memory rate
// (R7) memory bus clock is half platform clock
// (R8) platform clock never below 333 MHz
// (R9) core clock between 800 and grade maximum
// (R10) memory clock within 166 to 266 MHz
// (R11) reference at most 100 MHz below 1200
// (R12) both ratios chosen jointly within limits
// (R13) latch straps once at reset release
module sprs_strap_ratio #(
	parameter int REF_MHZ = 100,
	parameter int CORE_MAX_MHZ = `SPRS_CORE_MAX_MHZ,
	parameter int MEM_MAX_MHZ = `SPRS_MEM_MAX_MHZ
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// strap pins, shared with other functions after reset
	input wire logic [3:0] i_platform_ratio_strap,
	input wire logic i_core_ratio_strap_bit2,
	input wire logic i_core_ratio_strap_bit1,
	input wire logic i_core_ratio_strap_bit0,
	// decoded ratios
	output sprs_pkg::sprs_plat_ratio_type o_plat_ratio,
	output sprs_pkg::sprs_core_ratio_type o_core_ratio,
	output logic [4:0] o_mem_mult_halves,
	output logic o_ratios_valid,
	output logic o_range_ok
);
	import sprs_pkg::*;

	initial begin
		if (REF_MHZ > 1000 || MEM_MAX_MHZ < `SPRS_MEM_MIN_MHZ) begin
			$error("sprs_strap_ratio: unsupported parameters");
		end
	end

	// platform code to multiplier; zero marks a reserved code
	function automatic sprs_plat_ratio_type plat_decode(input logic [3:0] code);
		sprs_plat_ratio_type r;
		r.reserved = 1'b0;
		case (code)
			`SPRS_PLAT_CODE_16: r.mult = 5'h10;
			`SPRS_PLAT_CODE_2: r.mult = 5'h02;
			`SPRS_PLAT_CODE_3: r.mult = 5'h03;
			`SPRS_PLAT_CODE_4: r.mult = 5'h04;
			`SPRS_PLAT_CODE_5: r.mult = 5'h05;
			`SPRS_PLAT_CODE_6: r.mult = 5'h06;
			`SPRS_PLAT_CODE_8: r.mult = 5'h08;
			`SPRS_PLAT_CODE_9: r.mult = 5'h09;
			`SPRS_PLAT_CODE_10: r.mult = 5'h0a;
			`SPRS_PLAT_CODE_12: r.mult = 5'h0c;
			`SPRS_PLAT_CODE_20: r.mult = 5'h14;
			default: begin
				r.mult = 5'h00;
				r.reserved = 1'b1;
			end
		endcase
		return r;
	endfunction

	// core code to ratio in half steps
	function automatic sprs_core_ratio_type core_decode(input logic [2:0] code);
		sprs_core_ratio_type r;
		r.reserved = 1'b0;
		case (code)
			`SPRS_CORE_CODE_4_1: r.halves = 4'h8;
			`SPRS_CORE_CODE_9_2: r.halves = 4'h9;
			`SPRS_CORE_CODE_3_2: r.halves = 4'h3;
			`SPRS_CORE_CODE_2_1: r.halves = 4'h4;
			`SPRS_CORE_CODE_5_2: r.halves = 4'h5;
			`SPRS_CORE_CODE_3_1: r.halves = 4'h6;
			`SPRS_CORE_CODE_7_2: r.halves = 4'h7;
			default: begin
				r.halves = 4'h0;
				r.reserved = 1'b1;
			end
		endcase
		return r;
	endfunction

	sprs_state_type state_q;
	sprs_state_type state_d;
	sprs_straps_type straps;
	sprs_plat_ratio_type plat_dec;
	sprs_core_ratio_type core_dec;
	logic capture;

	// bit2 is the most significant core strap
	assign straps.plat = i_platform_ratio_strap; // see (R3)
	assign straps.core = {i_core_ratio_strap_bit2, i_core_ratio_strap_bit1,
		i_core_ratio_strap_bit0}; // see (R4)
	assign plat_dec = plat_decode(straps.plat); // see (R2)
	assign core_dec = core_decode(straps.core); // see (R5)

	// a capture happens only on the first cycle after reset release, so
	// later reuse of the pins as bus lines cannot disturb the ratios
	assign capture = state_q == SPRS_IN_RESET; // see (R13)
	always_comb begin
		case (state_q)
			SPRS_IN_RESET: state_d = SPRS_SAMPLE;
			SPRS_SAMPLE: state_d = SPRS_LOCKED;
			SPRS_LOCKED: state_d = SPRS_LOCKED;
			default: state_d = SPRS_LOCKED;
		endcase
	end

	// sequencer; the asynchronous reset loads constants only
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= SPRS_IN_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ratio latches, loaded once by the clocked capture
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_plat_ratio <= '{mult: `SPRS_PLAT_MULT_RST, reserved: 1'b0};
			o_core_ratio <= '{halves: `SPRS_CORE_HALF_RST, reserved: 1'b0};
			o_mem_mult_halves <= 5'h00;
			o_ratios_valid <= 1'b0;
		end else if (capture) begin
			o_plat_ratio <= plat_dec; // see (R1)
			o_core_ratio <= core_dec; // see (R4)
			// memory clock in half steps of reference: plat mult / 2 // see (R7)
			o_mem_mult_halves <= plat_dec.mult; // see (R6)
			o_ratios_valid <= 1'b1; // see (R13)
		end
	end

	sprs_range_check #(
		.REF_MHZ(REF_MHZ),
		.CORE_MAX_MHZ(CORE_MAX_MHZ),
		.MEM_MAX_MHZ(MEM_MAX_MHZ)
	) u_check (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_plat(o_plat_ratio),
		.i_core(o_core_ratio),
		.i_valid(o_ratios_valid),
		.o_range_ok(o_range_ok)
	);

	// latched ratios never move once valid
	a_ratio_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see (R13)
		$past(o_ratios_valid) |-> $stable(o_plat_ratio) && $stable(o_core_ratio))
		else $error("ratios changed after lock");

	// valid rises exactly one edge after release
	a_valid_once: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see (R13)
		!o_ratios_valid |=> o_ratios_valid [*3])
		else $error("valid not held after capture");

	// core code 010 reports reserved
	a_core_rsvd: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see (R5)
		capture && straps.core == 3'h2 |=> o_core_ratio.reserved && o_core_ratio.halves == 4'h0)
		else $error("reserved core code not flagged");

	// platform code 1101 gives twenty
	a_plat_twenty: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see (R2)
		capture && straps.plat == 4'hd |=> o_plat_ratio.mult == 5'h14)
		else $error("platform code 1101 not twenty");

	// platform code 0000 gives sixteen
	a_plat_sixteen: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see (R1)
		capture && straps.plat == 4'h0 |=> o_plat_ratio.mult == 5'h10 && !o_plat_ratio.reserved)
		else $error("platform code 0000 not sixteen");

	// core code 001 gives nine halves
	a_core_ninehalf: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see (R4)
		capture && straps.core == 3'h1 |=> o_core_ratio.halves == 4'h9)
		else $error("core code 001 not 9:2");

	// memory multiplier tracks platform multiplier
	a_mem_half: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see (R7)
		o_ratios_valid |-> o_mem_mult_halves == o_plat_ratio.mult)
		else $error("memory ratio not half platform");

	// reserved platform code never reports in range
	a_rsvd_range: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see (R12)
		o_plat_ratio.reserved |=> !o_range_ok)
		else $error("reserved strap judged in range");

endmodule // sprs_strap_ratio
